// ==== verilog/pwrt_pkg.sv ====
package pwrt_pkg;
    // Register map, byte addresses on the 8-bit register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] PRESCALE_OFS = 8'h38;
    localparam logic [ADDR_W-1:0] WAKE_CS_OFS = 8'h39;
    localparam logic [ADDR_W-1:0] RESTART_CS_OFS = 8'h3A;

    // Field positions in both control/status registers
    localparam int FLAG_BIT = 7;
    localparam int ACK_BIT = 6;
    localparam int INTERVAL_LSB = 0;
    localparam int INTERVAL_W = 6;

    // Values after reset, and the wake divider value forced by a zero wake interval
    localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 6'h3F;
    localparam logic [INTERVAL_W-1:0] PRESCALE_RST = 6'h1F;
    localparam logic [INTERVAL_W-1:0] INTERVAL_OFF = 6'h00;
    localparam logic [INTERVAL_W-1:0] DIVIDER_FORCED = 6'h3F;

    // Prescaler: ticks per wake clock = base + step * select
    localparam int PRESCALE_W = 11;
    localparam logic [PRESCALE_W-1:0] PRESCALE_BASE = 11'h1F8;
    localparam int PRESCALE_STEP_SHIFT = 4;

    // Terminal count used while the wake interrupt is disabled
    localparam logic [INTERVAL_W:0] DISABLED_TERM = 7'h40;
endpackage

// ==== verilog/pwrt_top.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Wake event flag (bit 7) set on wake interrupt, cleared by any reset.
// - Writing zero to the wake event flag position leaves it unchanged.
// - Writing one to wake ack (bit 6) clears wake flag; ack reads zero.
// - Wake interval sets wake ticks per wake interrupt, 1 to 63.
// - Changed wake interval restarts the wake count; same value ignored.
// - Accepted zero wake interval disables wake interrupt, forces divider to 63.
// - Zero wake interval write rejected while restart interval is zero.
// - Every reset presets the wake interval to 63.
// - Restart flag (bit 7) set on periodic reset; writes to it ignored.
// - Restart flag cleared only by power-on reset or acknowledge.
// - Writing one to restart ack (bit 6) clears restart flag; reads zero.
// - Restart interval sets wake events per periodic reset, 1 to 63.
// - Changed restart interval restarts its count; same value ignored.
// - Zero restart interval disables periodic reset if wake interval nonzero.
// - Zero restart interval write ignored while wake interval is zero.
// - Any reset presets the restart interval to 63.
// - Both counters count up, fire at programmed count, return to zero.
// - Reset and wake interrupt in same cycle: only the reset is issued.
// - Wake tick divides the 1 ms tick by 504 plus 16 times select.
////////////////////////////////////////////////////////////////////////////////
module pwrt_top
    import pwrt_pkg::*;
(
    input wire logic sys_clk, // 100 MHz clock
    input wire logic reset_n, // Power-on reset, async, active low
    input wire logic sys_reset, // Other system resets, sync, active high
    input wire logic lfo_tick, // One-cycle pulse per 1 ms oscillator tick
    input wire logic [pwrt_pkg::ADDR_W-1:0] reg_addr, // Register address
    input wire logic [pwrt_pkg::DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [pwrt_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
    output logic wake_irq_req, // Wake interrupt request level
    output logic periodic_reset // One-cycle periodic reset request
);
    import pwrt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [INTERVAL_W-1:0] prescale_sel_r;
    logic [INTERVAL_W-1:0] wake_int_r;
    logic [INTERVAL_W-1:0] rst_int_r;
    logic [PRESCALE_W-1:0] pre_cnt_r;
    logic [INTERVAL_W-1:0] wake_cnt_r;
    logic [INTERVAL_W-1:0] rst_cnt_r;
    logic wake_flag_r;
    logic rst_flag_r;
    logic wake_irq_r;
    logic prst_r;
    logic [DATA_W-1:0] rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_pre = reg_wr && (reg_addr == PRESCALE_OFS);
    wire wr_wake = reg_wr && (reg_addr == WAKE_CS_OFS);
    wire wr_rst = reg_wr && (reg_addr == RESTART_CS_OFS);
    wire [INTERVAL_W-1:0] wdata_int = reg_wdata[INTERVAL_LSB +: INTERVAL_W];
    wire wdata_zero = (wdata_int == INTERVAL_OFF);
    wire wake_off = (wake_int_r == INTERVAL_OFF);
    wire rst_off = (rst_int_r == INTERVAL_OFF);

    // Interval writes: change only, with the both-off interlock
    wire wake_int_wr = wr_wake && (wdata_int != wake_int_r)
        && !(wdata_zero && rst_off);
    wire rst_int_wr = wr_rst && (wdata_int != rst_int_r)
        && !(wdata_zero && wake_off);
    wire wake_ack = wr_wake && reg_wdata[ACK_BIT];
    wire rst_ack = wr_rst && reg_wdata[ACK_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler producing the wake clock tick
    wire [PRESCALE_W-1:0] pre_term = PRESCALE_BASE
        + {1'b0, prescale_sel_r, 4'b0000};
    wire [PRESCALE_W-1:0] pre_inc = pre_cnt_r + 11'h001;
    wire wclk = lfo_tick && (pre_inc == pre_term);
    wire [PRESCALE_W-1:0] pre_nxt = !lfo_tick ? pre_cnt_r :
        (wclk ? '0 : pre_inc);

    ////////////////////////////////////////////////////////////////////////////
    // Wake counter; while disabled it wraps at 64 to keep the restart clock
    wire [INTERVAL_W:0] wake_inc = {1'b0, wake_cnt_r} + 7'h01;
    wire [INTERVAL_W:0] wake_term = wake_off ? DISABLED_TERM :
        {1'b0, wake_int_r};
    wire rclk = wclk && (wake_inc == wake_term);
    wire [INTERVAL_W-1:0] wake_cnt_nxt = wake_int_wr ?
        (wdata_zero ? DIVIDER_FORCED : INTERVAL_OFF) :
        (!wclk ? wake_cnt_r :
        (rclk ? INTERVAL_OFF : wake_inc[INTERVAL_W-1:0]));

    ////////////////////////////////////////////////////////////////////////////
    // Restart counter, clocked by each wake period
    wire [INTERVAL_W:0] rst_inc = {1'b0, rst_cnt_r} + 7'h01;
    wire rst_hit = rclk && !rst_off
        && (rst_inc == {1'b0, rst_int_r});
    wire [INTERVAL_W-1:0] rst_cnt_nxt = rst_int_wr ? INTERVAL_OFF :
        ((!rclk || rst_off) ? rst_cnt_r :
        (rst_hit ? INTERVAL_OFF : rst_inc[INTERVAL_W-1:0]));

    // Wake interrupt only when enabled and not beaten by a reset
    wire wake_hit = rclk && !wake_off && !rst_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Flags: a set in the ack cycle wins
    wire wake_flag_nxt = wake_hit || (wake_flag_r && !wake_ack);
    wire rst_flag_nxt = rst_hit || (rst_flag_r && !rst_ack);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; ack bits read zero, unmapped addresses read zero
    wire [DATA_W-1:0] rd_mux =
        (reg_addr == PRESCALE_OFS) ? {2'b00, prescale_sel_r} :
        (reg_addr == WAKE_CS_OFS) ? {wake_flag_r, 1'b0, wake_int_r} :
        (reg_addr == RESTART_CS_OFS) ? {rst_flag_r, 1'b0, rst_int_r} :
        8'h00;
    wire [DATA_W-1:0] rdata_nxt = reg_rd ? rd_mux : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Prescale select: power-on reset only
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_sel_r <= PRESCALE_RST;
        end else if (wr_pre) begin
            prescale_sel_r <= wdata_int;
        end
    end

    // Interval fields: every reset presets them
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_int_r <= INTERVAL_RST;
            rst_int_r <= INTERVAL_RST;
        end else if (sys_reset) begin
            wake_int_r <= INTERVAL_RST;
            rst_int_r <= INTERVAL_RST;
        end else begin
            if (wake_int_wr) begin
                wake_int_r <= wdata_int;
            end
            if (rst_int_wr) begin
                rst_int_r <= wdata_int;
            end
        end
    end

    // Counters restart on every reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt_r <= '0;
            wake_cnt_r <= INTERVAL_OFF;
            rst_cnt_r <= INTERVAL_OFF;
        end else if (sys_reset) begin
            pre_cnt_r <= '0;
            wake_cnt_r <= INTERVAL_OFF;
            rst_cnt_r <= INTERVAL_OFF;
        end else begin
            pre_cnt_r <= pre_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    // Wake flag cleared by any reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_flag_r <= 1'b0;
            wake_irq_r <= 1'b0;
        end else if (sys_reset) begin
            wake_flag_r <= 1'b0;
            wake_irq_r <= 1'b0;
        end else begin
            wake_flag_r <= wake_flag_nxt;
            wake_irq_r <= wake_flag_nxt;
        end
    end

    // Restart flag survives system resets
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_flag_r <= 1'b0;
            prst_r <= 1'b0;
        end else begin
            rst_flag_r <= sys_reset ? rst_flag_r : rst_flag_nxt;
            prst_r <= rst_hit && !sys_reset;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign wake_irq_req = wake_irq_r;
    assign periodic_reset = prst_r;
endmodule
`default_nettype wire

// ==== verification/pwrt_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwrt_checker
    import pwrt_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // POR
    input wire logic sys_reset, // Sys reset
    input wire logic lfo_tick, // Tick
    input wire logic [ADDR_W-1:0] reg_addr, // Addr
    input wire logic [DATA_W-1:0] reg_wdata, // Wdata
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [DATA_W-1:0] reg_rdata, // Rdata
    input wire logic wake_irq_req, // Irq
    input wire logic periodic_reset // Restart
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire ack_wr = reg_wr && reg_addr == WAKE_CS_OFS && reg_wdata[ACK_BIT];
    wire rd_cs = reg_rd
        && (reg_addr == WAKE_CS_OFS || reg_addr == RESTART_CS_OFS);
    property p_ack_zero; rd_cs |=> !reg_rdata[ACK_BIT]; endproperty
    a_ack_zero:
        assert property (p_ack_zero) else $error("ack bit read as one");
    property p_sys_clr;
        sys_reset |=> !wake_irq_req && !periodic_reset;
    endproperty
    a_sys_clr:
        assert property (p_sys_clr) else $error("outputs kept in reset");
    property p_gap; periodic_reset |=> !periodic_reset [*8]; endproperty
    a_gap:
        assert property (p_gap) else $error("restart pulse repeated");
    property p_no_both; periodic_reset |-> !$rose(wake_irq_req); endproperty
    a_no_both:
        assert property (p_no_both) else $error("irq beside restart");
    property p_hold; wake_irq_req && !sys_reset && !ack_wr |=> wake_irq_req;
    endproperty
    a_hold:
        assert property (p_hold) else $error("irq dropped alone");
    property p_fall; $fell(wake_irq_req) |-> $past(sys_reset) || $past(ack_wr);
    endproperty
    a_fall:
        assert property (p_fall) else $error("irq fell without cause");
    property p_flag; reg_rd && reg_addr == WAKE_CS_OFS
        |=> reg_rdata[FLAG_BIT] == $past(wake_irq_req); endproperty
    a_flag:
        assert property (p_flag) else $error("flag read mismatch");
    property p_pre;
        reg_rd && reg_addr == PRESCALE_OFS |=> reg_rdata[7:6] == 2'b00;
    endproperty
    a_pre:
        assert property (p_pre) else $error("prescale top bits set");
endmodule
bind pwrt_top pwrt_checker u_chk(.sys_clk(sys_clk), .reset_n(reset_n),
    .sys_reset(sys_reset), .lfo_tick(lfo_tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wake_irq_req(wake_irq_req),
    .periodic_reset(periodic_reset));
`default_nettype wire

// ==== verification/pwrt_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwrt_core_model #(parameter int HOLD = 4) (
    input wire logic sys_clk, // Clock
    input wire logic reset_n, // POR
    input wire logic periodic_reset, // Restart request
    output logic sys_reset // Core reset back
);
    logic [3:0] cnt_r;
    // Core holds its reset a few cycles per request
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) cnt_r <= 4'h0;
        else if (periodic_reset) cnt_r <= 4'(HOLD);
        else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
    assign sys_reset = cnt_r != 4'h0;
endmodule
`default_nettype wire

// ==== verification/pwrt_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwrt_top_tb_top;
    import pwrt_pkg::*;
    logic sys_clk = 0, reset_n = 0, lfo_tick = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire wake_irq_req, periodic_reset, sys_reset;
    int bad_count = 0, cmp_count = 0, i;
    pwrt_top u_dut(.sys_clk(sys_clk), .reset_n(reset_n), .sys_reset(sys_reset),
        .lfo_tick(lfo_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wake_irq_req(wake_irq_req), .periodic_reset(periodic_reset));
    pwrt_core_model u_core(.sys_clk(sys_clk), .reset_n(reset_n),
        .periodic_reset(periodic_reset), .sys_reset(sys_reset));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, exp, input string what);
        @(posedge sys_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1 check(what, reg_rdata, exp);
    endtask
    task automatic t_reset_values;
        rd(WAKE_CS_OFS, 8'h3F, "wake_cs");
        rd(RESTART_CS_OFS, 8'h3F, "restart_cs");
        rd(PRESCALE_OFS, 8'h1F, "prescale");
    endtask
    task automatic t_wake_cycle;
        wr(PRESCALE_OFS, 8'h00);
        wr(RESTART_CS_OFS, 8'h02);
        wr(WAKE_CS_OFS, 8'h01);
        for (i = 0; i < 1200 && wake_irq_req !== 1'b1; i++) begin
            @(posedge sys_clk) #1;
        end
        check("wake_irq", {7'h0, wake_irq_req}, 8'h01);
        rd(WAKE_CS_OFS, 8'h81, "wake_cs");
        wr(WAKE_CS_OFS, 8'h01);
        rd(WAKE_CS_OFS, 8'h81, "wake_cs");
        wr(WAKE_CS_OFS, 8'h41);
        rd(WAKE_CS_OFS, 8'h01, "wake_cs");
        for (i = 0; i < 1200 && periodic_reset !== 1'b1; i++) begin
            @(posedge sys_clk) #1;
        end
        check("periodic_reset", {7'h0, periodic_reset}, 8'h01);
        check("wake_irq", {7'h0, wake_irq_req}, 8'h00);
        repeat (8) @(posedge sys_clk);
        rd(RESTART_CS_OFS, 8'hBF, "restart_cs");
        // Ack with the interval kept at its preset so only the flag clears
        wr(RESTART_CS_OFS, 8'h7F);
        rd(RESTART_CS_OFS, 8'h3F, "restart_cs");
    endtask
    task automatic t_interlock;
        wr(RESTART_CS_OFS, 8'h00);
        rd(RESTART_CS_OFS, 8'h00, "restart_cs");
        wr(WAKE_CS_OFS, 8'h00);
        rd(WAKE_CS_OFS, 8'h3F, "wake_cs");
        wr(RESTART_CS_OFS, 8'h05);
        wr(WAKE_CS_OFS, 8'h00);
        rd(WAKE_CS_OFS, 8'h00, "wake_cs");
        wr(RESTART_CS_OFS, 8'h00);
        rd(RESTART_CS_OFS, 8'h05, "restart_cs");
        rd(8'h55, 8'h00, "unmapped");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1;
        t_reset_values();
        t_wake_cycle();
        t_interlock();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
